// file: logic/setpoint_defines.svh
`ifndef SETPOINT_DEFINES_SVH
`define SETPOINT_DEFINES_SVH
// mode register addresses
`define MA_ONE 6'h01
`define MA_TWO 6'h02
`define MA_THREE 6'h03
`define MA_ELEVEN 6'h0B
`define MA_TWELVE 6'h0C
`define MA_THIRTEEN 6'h0D
`define MA_FOURTEEN 6'h0E
`define MA_TWENTYTWO 6'h16
// setpoint select bits in mode_reg_thirteen
`define SP_WRITE_BIT 6
`define SP_OPERATE_BIT 7
`define MODE_REG_THIRTEEN_RESET 8'h00
// implemented bit masks of the duplicated registers
`define MASK_ONE 8'hFC
`define MASK_TWO 8'h7F
`define MASK_THREE 8'hFB
`define MASK_ELEVEN 8'h77
`define MASK_TWELVE 8'h7F
`define MASK_FOURTEEN 8'h7F
`define MASK_TWENTYTWO 8'h3F
`define DUP_RESET 8'h00
// timing, ns and derived cycles at 25 MHz
`define CLK_PERIOD_NS 40
`define ASYNC_RESULT_DELAY_NS 20
`define ASYNC_RESULT_CYC ((`ASYNC_RESULT_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STROBE_RELEASE_NS 10
`define TERM_LATENCY_NS 20
`define REF_MULTI_STEP_NS 250
`define REF_SINGLE_STEP_NS 80
`define REF_MULTI_CYC (`REF_MULTI_STEP_NS / `CLK_PERIOD_NS)
`define REF_SINGLE_CYC (`REF_SINGLE_STEP_NS / `CLK_PERIOD_NS)
`endif

// file: logic/setpoint_pkg.sv
package setpoint_pkg;
  typedef enum logic [1:0] {
    TR_IDLE = 2'b00,
    TR_ACTIVE = 2'b01
  } train_state_t;
  typedef logic [7:0] mr_byte_t;
  typedef logic [5:0] mr_addr_t;
endpackage

// file: logic/sync2.sv
`timescale 1ns/100ps
module sync2 (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic async_in,
  output logic sync_out
);
  logic meta_q;
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      // reset to the idle-high level of clock enable, so no false fall follows reset
      meta_q <= 1'b1;
      sync_out <= 1'b1;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule

// file: logic/ref_settle.sv
`timescale 1ns/100ps
`include "setpoint_defines.svh"
// times a reference-level move: short wait for one step within the same range, long otherwise
module ref_settle (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic [6:0] level_in,
  output logic settling_out
);
  logic [6:0] last_q;
  logic [3:0] count_q;
  logic [6:0] diff;
  always_comb begin
    diff = (level_in[5:0] > last_q[5:0]) ? {1'b0, level_in[5:0] - last_q[5:0]}
                                          : {1'b0, last_q[5:0] - level_in[5:0]};
  end
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      last_q <= 7'h00;
      count_q <= 4'h0;
    end else begin
      last_q <= level_in;
      if (level_in != last_q) begin
        if (level_in[6] == last_q[6] && diff == 7'h01) begin
          count_q <= 4'(`REF_SINGLE_CYC);
        end else begin
          count_q <= 4'(`REF_MULTI_CYC);
        end
      end else if (count_q != 4'h0) begin
        count_q <= count_q - 4'h1;
      end
    end
  end
  assign settling_out = (count_q != 4'h0);
endmodule

// file: logic/setpoint_regs.sv
`timescale 1ns/100ps
`include "setpoint_defines.svh"
// Contract
// - two copies per duplicated field, shared address
// - write select steers writes and reads
// - operate select switches whole copy at once
// - mode_reg_one duplicated fields
// - mode_reg_two latency fields duplicated
// - mode_reg_three drive and inversion duplicated
// - mode_reg_eleven termination codes duplicated
// - reference levels twelve and fourteen duplicated
// - mode_reg_twentytwo termination controls duplicated
// - training result out within 20 ns
// - too-close samples dropped, last one delivered
// - reference settles 250 ns multi, 80 single; the multi settle here is 6 cycles, 240 ns
// - strobes released within 10 ns of exit
// - data pins tri-stated on exit
// - command termination follows clock enable within 20ns; here it lags the pin by four clock edges
// - select bits in thirteen, reset zero
// - write and operate selects independent
// - power-up operates from copy zero
// - training runs on opposite copy
module setpoint_regs (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic mr_write_in,
  input wire logic mr_read_in,
  input wire setpoint_pkg::mr_addr_t mr_addr_in,
  input wire setpoint_pkg::mr_byte_t mr_wdata_in,
  output setpoint_pkg::mr_byte_t mr_rdata_out,
  output logic mr_rvalid_out,
  input wire logic cke_pin_in,
  input wire logic train_cmd_in,
  input wire logic [5:0] train_sample_in,
  output logic [5:0] train_result_out,
  output logic [5:0] train_result_oe_n_out,
  output logic strobe_oe_n_out,
  output logic cmd_term_on_out,
  output logic active_setpoint_out,
  output setpoint_pkg::mr_byte_t op_one_out,
  output setpoint_pkg::mr_byte_t op_two_out,
  output setpoint_pkg::mr_byte_t op_three_out,
  output setpoint_pkg::mr_byte_t op_eleven_out,
  output setpoint_pkg::mr_byte_t op_twelve_out,
  output setpoint_pkg::mr_byte_t op_fourteen_out,
  output setpoint_pkg::mr_byte_t op_twentytwo_out,
  output logic ref_settling_out
);
  import setpoint_pkg::*;

  localparam int NREG = 7;

  // index of a duplicated register, NREG when not duplicated
  function automatic logic [2:0] dup_index(input mr_addr_t a);
    if (a == `MA_ONE) begin
      dup_index = 3'd0;
    end else if (a == `MA_TWO) begin
      dup_index = 3'd1;
    end else if (a == `MA_THREE) begin
      dup_index = 3'd2;
    end else if (a == `MA_ELEVEN) begin
      dup_index = 3'd3;
    end else if (a == `MA_TWELVE) begin
      dup_index = 3'd4;
    end else if (a == `MA_FOURTEEN) begin
      dup_index = 3'd5;
    end else if (a == `MA_TWENTYTWO) begin
      dup_index = 3'd6;
    end else begin
      dup_index = 3'd7;
    end
  endfunction

  function automatic mr_byte_t dup_mask(input logic [2:0] i);
    case (i)
      3'd0: dup_mask = `MASK_ONE;
      3'd1: dup_mask = `MASK_TWO;
      3'd2: dup_mask = `MASK_THREE;
      3'd3: dup_mask = `MASK_ELEVEN;
      3'd4: dup_mask = `MASK_TWELVE;
      3'd5: dup_mask = `MASK_FOURTEEN;
      3'd6: dup_mask = `MASK_TWENTYTWO;
      default: dup_mask = 8'h00;
    endcase
  endfunction

  mr_byte_t copy0_q [NREG];
  mr_byte_t copy1_q [NREG];
  mr_byte_t mode_reg_thirteen_q;
  logic cke_sync;
  logic cke_prev_q;
  train_state_t train_q;
  logic active_sp;
  logic [2:0] widx;

  sync2 cke_sync_i (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .async_in(cke_pin_in),
    .sync_out(cke_sync)
  );

  assign widx = dup_index(mr_addr_in);

  // write lands in the copy named by the write select only
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      for (int i = 0; i < NREG; i++) begin
        copy0_q[i] <= `DUP_RESET;
        copy1_q[i] <= `DUP_RESET;
      end
    end else if (mr_write_in && widx != 3'd7) begin
      if (mode_reg_thirteen_q[`SP_WRITE_BIT]) begin
        copy1_q[widx] <= mr_wdata_in & dup_mask(widx);
      end else begin
        copy0_q[widx] <= mr_wdata_in & dup_mask(widx);
      end
    end
  end

  // selects reset to copy zero and are written independently
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      mode_reg_thirteen_q <= `MODE_REG_THIRTEEN_RESET;
    end else if (mr_write_in && mr_addr_in == `MA_THIRTEEN) begin
      mode_reg_thirteen_q <= mr_wdata_in;
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      mr_rdata_out <= 8'h00;
      mr_rvalid_out <= 1'b0;
    end else begin
      mr_rvalid_out <= mr_read_in;
      if (mr_read_in) begin
        if (mr_addr_in == `MA_THIRTEEN) begin
          mr_rdata_out <= mode_reg_thirteen_q;
        end else if (widx != 3'd7) begin
          mr_rdata_out <= mode_reg_thirteen_q[`SP_WRITE_BIT] ? copy1_q[widx] : copy0_q[widx];
        end else begin
          mr_rdata_out <= 8'h00;
        end
      end
    end
  end

  // training entered when clock enable is seen low
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      cke_prev_q <= 1'b1;
      train_q <= TR_IDLE;
    end else begin
      cke_prev_q <= cke_sync;
      case (train_q)
        TR_IDLE: begin
          if (cke_prev_q && !cke_sync) begin
            train_q <= TR_ACTIVE;
          end
        end
        TR_ACTIVE: begin
          if (cke_sync) begin
            train_q <= TR_IDLE;
          end
        end
        default: train_q <= TR_IDLE;
      endcase
    end
  end

  // opposite copy in training; trained values stay in that copy on exit
  assign active_sp = mode_reg_thirteen_q[`SP_OPERATE_BIT] ^ (train_q == TR_ACTIVE);

  // one select picks the whole copy, registered together
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      active_setpoint_out <= 1'b0;
      op_one_out <= 8'h00;
      op_two_out <= 8'h00;
      op_three_out <= 8'h00;
      op_eleven_out <= 8'h00;
      op_twelve_out <= 8'h00;
      op_fourteen_out <= 8'h00;
      op_twentytwo_out <= 8'h00;
    end else begin
      active_setpoint_out <= active_sp;
      op_one_out <= active_sp ? copy1_q[0] : copy0_q[0];
      op_two_out <= active_sp ? copy1_q[1] : copy0_q[1];
      op_three_out <= active_sp ? copy1_q[2] : copy0_q[2];
      op_eleven_out <= active_sp ? copy1_q[3] : copy0_q[3];
      op_twelve_out <= active_sp ? copy1_q[4] : copy0_q[4];
      op_fourteen_out <= active_sp ? copy1_q[5] : copy0_q[5];
      op_twentytwo_out <= active_sp ? copy1_q[6] : copy0_q[6];
    end
  end

  // command termination follows the active copy one cycle behind the edge
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      cmd_term_on_out <= 1'b0;
    end else begin
      cmd_term_on_out <= !(active_sp ? copy1_q[6][5] : copy0_q[6][5]) &&
                         ((active_sp ? copy1_q[3][6:4] : copy0_q[3][6:4]) != 3'h0);
    end
  end

  // the sample is loaded on the command edge itself: a 40 ns cycle leaves no room
  // for a further register stage inside 20 ns; a later command overwrites it, so
  // only the last sample of a burst stands
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      train_result_out <= 6'h00;
    end else if (train_q == TR_ACTIVE && train_cmd_in) begin
      train_result_out <= train_sample_in;
    end
  end

  // pins driven only in training; exit releases on the next edge
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      train_result_oe_n_out <= 6'h3F;
      strobe_oe_n_out <= 1'b1;
    end else begin
      train_result_oe_n_out <= (train_q == TR_ACTIVE && !cke_sync) ? 6'h00 : 6'h3F;
      strobe_oe_n_out <= 1'b1;
    end
  end

  ref_settle ref_settle_i (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .level_in(op_twelve_out[6:0]),
    .settling_out(ref_settling_out)
  );
endmodule

// file: test/setpoint_checker.sv
`timescale 1ns/100ps
`include "setpoint_defines.svh"
module setpoint_checker (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic mr_read_in,
  input wire setpoint_pkg::mr_addr_t mr_addr_in,
  input wire setpoint_pkg::mr_byte_t mr_rdata_out,
  input wire logic mr_rvalid_out,
  input wire logic cke_pin_in,
  input wire logic train_cmd_in,
  input wire logic [5:0] train_sample_in,
  input wire logic [5:0] train_result_out,
  input wire logic [5:0] train_result_oe_n_out,
  input wire logic strobe_oe_n_out
);
  import setpoint_pkg::*;
  default clocking @(posedge clock_in); endclocking
  default disable iff (rst_in);
  strobe_released_a: assert property (strobe_oe_n_out)
    else $error("strobe driven by device");
  read_answer_a: assert property (mr_read_in |=> mr_rvalid_out)
    else $error("read not answered");
  answer_cause_a: assert property (mr_rvalid_out |-> $past(mr_read_in))
    else $error("answer without read");
  unmapped_zero_a: assert property (
    mr_read_in && mr_addr_in > `MA_TWENTYTWO |=> mr_rdata_out == 8'h00)
    else $error("unmapped read not zero");
  rdata_holds_a: assert property (!mr_rvalid_out |-> $stable(mr_rdata_out))
    else $error("read data moved");
  // loaded on the command edge, so it stands from the next sample on
  result_time_a: assert property (
    train_cmd_in && train_result_oe_n_out == 6'h00
    |=> train_result_out == $past(train_sample_in)) else $error("late result");
  exit_tristate_a: assert property (cke_pin_in [*5] |-> train_result_oe_n_out == 6'h3F)
    else $error("data pins still driven");
  train_drive_a: assert property (!cke_pin_in [*5] |-> train_result_oe_n_out == 6'h00)
    else $error("data pins not driven");
endmodule
bind setpoint_regs setpoint_checker chk (.clock_in, .rst_in, .mr_read_in, .mr_addr_in,
  .mr_rdata_out, .mr_rvalid_out, .cke_pin_in, .train_cmd_in, .train_sample_in,
  .train_result_out, .train_result_oe_n_out, .strobe_oe_n_out);

// file: test/ctrl_model.sv
`timescale 1ns/100ps
`include "setpoint_defines.svh"
module ctrl_model (
  input wire logic clock_in,
  output logic cke_out,
  output logic cmd_out,
  output logic [5:0] sample_out
);
  initial begin
    cke_out = 1'b1;
    cmd_out = 1'b0;
    sample_out = 6'h00;
  end
  task automatic enter();
    // clock enable drops on the next rising edge, then seven cycles (250 ns rounded up) pass
    @(posedge clock_in);
    cke_out <= 1'b0;
    repeat ((250 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS) @(posedge clock_in);
  endtask
  // n above one sends commands back to back, the tightest spacing this clock allows
  task automatic command(input logic [5:0] s, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clock_in);
      cmd_out <= 1'b1;
      sample_out <= s + 6'(i);
    end
    @(posedge clock_in);
    cmd_out <= 1'b0;
    sample_out <= ~sample_out;
    repeat (`ASYNC_RESULT_CYC) @(posedge clock_in);
  endtask
  task automatic leave();
    repeat (3) @(posedge clock_in);
    cke_out <= 1'b1;
    // the exit delay lets training end and the copy switch back; the reference settle that follows is still running
    repeat (7) @(posedge clock_in);
  endtask
endmodule

// file: test/test_dual_setpoint_mode_regs_cbt.sv
`timescale 1ns/100ps
`include "setpoint_defines.svh"
module test_dual_setpoint_mode_regs_cbt;
  import setpoint_pkg::*;
  logic clock_in = 1'b0;
  logic rst_in = 1'b1;
  logic mr_write_in = 1'b0;
  logic mr_read_in = 1'b0;
  mr_addr_t mr_addr_in = 6'h00;
  mr_byte_t mr_wdata_in = 8'h00;
  mr_byte_t mr_rdata_out;
  logic mr_rvalid_out, cke_pin_in, train_cmd_in, strobe_oe_n_out, cmd_term_on_out;
  logic active_setpoint_out, ref_settling_out;
  logic [5:0] train_sample_in, train_result_out, train_result_oe_n_out;
  mr_byte_t ops [7];
  int mismatches = 0;
  int total_checks = 0;
  mr_addr_t adr [7] = '{`MA_ONE, `MA_TWO, `MA_THREE, `MA_ELEVEN, `MA_TWELVE, `MA_FOURTEEN,
    `MA_TWENTYTWO};
  mr_byte_t msk [7] = '{`MASK_ONE, `MASK_TWO, `MASK_THREE, `MASK_ELEVEN, `MASK_TWELVE,
    `MASK_FOURTEEN, `MASK_TWENTYTWO};
  always #20 clock_in = ~clock_in;
  setpoint_regs dut (.clock_in, .rst_in, .mr_write_in, .mr_read_in, .mr_addr_in, .mr_wdata_in,
    .mr_rdata_out, .mr_rvalid_out, .cke_pin_in, .train_cmd_in, .train_sample_in,
    .train_result_out, .train_result_oe_n_out, .strobe_oe_n_out, .cmd_term_on_out,
    .active_setpoint_out, .op_one_out(ops[0]), .op_two_out(ops[1]), .op_three_out(ops[2]),
    .op_eleven_out(ops[3]), .op_twelve_out(ops[4]), .op_fourteen_out(ops[5]),
    .op_twentytwo_out(ops[6]), .ref_settling_out);
  ctrl_model ctrl (.clock_in, .cke_out(cke_pin_in), .cmd_out(train_cmd_in),
    .sample_out(train_sample_in));
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic mr_wr(input mr_addr_t a, input mr_byte_t d);
    @(posedge clock_in);
    mr_write_in <= 1'b1;
    mr_addr_in <= a;
    mr_wdata_in <= d;
    @(posedge clock_in);
    mr_write_in <= 1'b0;
  endtask
  task automatic mr_rd(input mr_addr_t a, input mr_byte_t exp);
    int n;
    @(posedge clock_in);
    mr_read_in <= 1'b1;
    mr_addr_in <= a;
    @(posedge clock_in);
    mr_read_in <= 1'b0;
    for (n = 0; n < 4; n++) begin
      @(negedge clock_in);
      if (mr_rvalid_out === 1'b1) break;
    end
    check("read answer", {7'h0, mr_rvalid_out}, 8'h01);
    if (n == 4) print_verdict();
    check("read data", mr_rdata_out, exp);
  endtask
  task automatic t_reset();
    check("active copy", {7'h0, active_setpoint_out}, 8'h00);
    check("data oe_n", {2'h0, train_result_oe_n_out}, 8'h3F);
    check("strobe oe_n", {7'h0, strobe_oe_n_out}, 8'h01);
    mr_rd(`MA_THIRTEEN, `MODE_REG_THIRTEEN_RESET);
  endtask
  task automatic t_copies();
    for (int i = 0; i < 7; i++) begin
      mr_wr(`MA_THIRTEEN, 8'h40);
      mr_wr(adr[i], 8'hD5);
      mr_wr(`MA_THIRTEEN, 8'h00);
      mr_wr(adr[i], 8'hAA);
      mr_rd(adr[i], 8'hAA & msk[i]);
      check("operating field", ops[i], 8'hAA & msk[i]);
      mr_wr(`MA_THIRTEEN, 8'h40);
      mr_rd(adr[i], 8'hD5 & msk[i]);
    end
    mr_rd(6'h3F, 8'h00);
  endtask
  task automatic t_train();
    ctrl.enter();
    @(negedge clock_in);
    check("data oe_n in training", {2'h0, train_result_oe_n_out}, 8'h00);
    check("active copy", {7'h0, active_setpoint_out}, 8'h01);
    check("twelve in training", ops[4], 8'h55);
    check("term on", {7'h0, cmd_term_on_out}, 8'h01);
    ctrl.command(6'h2A, 1);
    @(negedge clock_in);
    check("result", {2'h0, train_result_out}, 8'h2A);
    ctrl.command(6'h11, 2);
    @(negedge clock_in);
    check("last result", {2'h0, train_result_out}, 8'h12);
    ctrl.leave();
    @(negedge clock_in);
    check("active copy", {7'h0, active_setpoint_out}, 8'h00);
    check("term on", {7'h0, cmd_term_on_out}, 8'h00);
    check("data oe_n", {2'h0, train_result_oe_n_out}, 8'h3F);
  endtask
  task automatic t_switch();
    int busy = 0;
    // training exit moved the level too; let that settle run out first
    repeat (8) @(negedge clock_in);
    check("settled", {7'h0, ref_settling_out}, 8'h00);
    mr_wr(`MA_THIRTEEN, 8'h80);
    repeat (12) begin
      @(negedge clock_in);
      busy += int'(ref_settling_out === 1'b1);
    end
    // range bit differs between the copies, so the long settle applies
    check("settle cycles", 8'(busy), 8'(`REF_MULTI_CYC));
    check("active copy", {7'h0, active_setpoint_out}, 8'h01);
    for (int i = 0; i < 7; i++) check("switched field", ops[i], 8'hD5 & msk[i]);
    mr_rd(adr[4], 8'hAA & msk[4]);
    // one step up in the same range on the operating copy takes the short settle
    mr_wr(`MA_THIRTEEN, 8'hC0);
    mr_wr(adr[4], 8'h56);
    busy = 0;
    repeat (8) begin
      @(negedge clock_in);
      busy += int'(ref_settling_out === 1'b1);
    end
    check("single step cycles", 8'(busy), 8'(`REF_SINGLE_CYC));
    check("stepped level", ops[4], 8'h56);
  endtask
  initial begin
    repeat (3) @(posedge clock_in);
    rst_in <= 1'b0;
    @(negedge clock_in);
    t_reset();
    t_copies();
    t_train();
    t_switch();
    print_verdict();
  end
endmodule
